// *** verilog/ctm_top.v ***
`timescale 1ns/1ps
`include "ctm_consts.vh"

module ctm_top (
  // Clock and reset
  input  wire       CLOCK_IN,
  input  wire       RST_N_IN,
  // Register port
  input  wire [2:0] ADDR_IN,
  input  wire [7:0] WR_DATA_IN,
  input  wire       WR_EN_IN,
  input  wire       RD_EN_IN,
  output reg  [7:0] RD_DATA_OUT,
  // Clock sources
  input  wire       TBC_TICK_IN,
  input  wire       EXT_CLOCK_PIN_IN,
  // Timer output pins
  output reg        TIMER_OUTPUT_PIN_OUT,
  output reg        TIMER_OUTPUT_PIN_OE_OUT,
  output reg        TIMER_OUTPUT_PIN_B_OUT,
  output reg        TIMER_OUTPUT_PIN_B_OE_OUT,
  // Match events
  output reg        PERIOD_MATCH_OUT,
  output reg        COMPARE_A_MATCH_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0] ctrl0_reg;
  reg  [7:0] ctrl1_reg;
  reg  [9:0] count_reg;
  reg  [9:0] cmpa_reg;
  reg  [7:0] hold_reg;
  reg  [5:0] div_reg;
  reg  [2:0] ext_sync_reg;
  reg        ext_lvl_reg;
  reg        out_reg;
  reg        out_next;
  reg  [9:0] count_next;
  reg  [7:0] rd_next;
  reg        tick;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire       pause    = ctrl0_reg[`CTM_C0_PAUSE];
  wire [2:0] cksel    = ctrl0_reg[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
  wire       run      = ctrl0_reg[`CTM_C0_RUN];
  wire [2:0] period   = ctrl0_reg[`CTM_C0_RP_HI:`CTM_C0_RP_LO];
  wire [1:0] mode     = ctrl1_reg[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  wire [1:0] io_fn    = ctrl1_reg[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  wire       init_lvl = ctrl1_reg[`CTM_C1_INIT];
  wire       pol      = ctrl1_reg[`CTM_C1_POL];
  wire       dpx      = ctrl1_reg[`CTM_C1_DPX];
  wire       cclr     = ctrl1_reg[`CTM_C1_CCLR];

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire       wr_c0    = WR_EN_IN && (ADDR_IN == `CTM_ADDR_CTRL0);
  wire       run_rise = wr_c0 && !run && WR_DATA_IN[`CTM_C0_RUN];

  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  function hit;
    input [2:0] addr;
    input [2:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Divider tap is due when every masked bit is set
  function div_due;
    input [5:0] div;
    input [5:0] mask;
    begin
      div_due = ((div & mask) == mask);
    end
  endfunction

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // High clock taken as the system clock; one shared divider
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      div_reg <= 6'h00;
    end else begin
      div_reg <= div_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // External pin synchroniser
  // ----------------------------------------------------------------
  // three stage sync
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ext_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], EXT_CLOCK_PIN_IN};
    end
  end

  // Accepted level moves only once stages two and three agree
  wire ext_agree = (ext_sync_reg[1] == ext_sync_reg[2]);
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ext_lvl_reg <= 1'b0;
    end else if (ext_agree) begin
      ext_lvl_reg <= ext_sync_reg[2];
    end
  end

  // One tick per accepted change; a pin idling high gives one edge after reset
  wire ext_rise  = ext_agree && ext_sync_reg[2] && !ext_lvl_reg;
  wire ext_fall  = ext_agree && !ext_sync_reg[2] && ext_lvl_reg;

  // ----------------------------------------------------------------
  // Count tick selection
  // ----------------------------------------------------------------
  always @* begin
    tick = 1'b0;
    case (cksel)
      `CTM_CK_SYS_DIV4:  tick = div_due(div_reg, `CTM_DIV4_MASK);
      `CTM_CK_SYS:       tick = 1'b1;
      `CTM_CK_HI_DIV16:  tick = div_due(div_reg, `CTM_DIV16_MASK);
      `CTM_CK_HI_DIV64:  tick = div_due(div_reg, `CTM_DIV64_MASK);
      `CTM_CK_TBC:       tick = TBC_TICK_IN;
      `CTM_CK_NONE:      tick = 1'b0;
      `CTM_CK_EXT_RISE:  tick = ext_rise;
      `CTM_CK_EXT_FALL:  tick = ext_fall;
      default:           tick = 1'b0;
    endcase
  end

  wire       advance = tick && run && !pause;

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // Matches judged on the value the counter is about to reach
  wire [9:0] inc     = count_reg + 10'h001;
  wire       p_match = advance && (inc[9:7] == period) && (inc[6:0] == 7'h00);
  wire       a_match = advance && (inc == cmpa_reg);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always @* begin
    count_next = count_reg;
    // Run rise outranks counting; clears outrank the increment
    if (run_rise) begin
      count_next = 10'h000;
    end else if (advance) begin
      count_next = inc;
      if (!cclr && p_match) begin
        count_next = 10'h000;
      end
      if (cclr && a_match) begin
        count_next = 10'h000;
      end
    end
  end

  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      count_reg <= `CTM_RST_CNT;
    end else begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // Match events
  // ----------------------------------------------------------------
  // Period zero matches at overflow, so overflow also flags
  // period event pulse
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      PERIOD_MATCH_OUT <= 1'b0;
    end else begin
      PERIOD_MATCH_OUT <= p_match;
    end
  end

  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      COMPARE_A_MATCH_OUT <= 1'b0;
    end else begin
      COMPARE_A_MATCH_OUT <= a_match;
    end
  end

  // ----------------------------------------------------------------
  // Output waveform
  // ----------------------------------------------------------------
  wire [9:0] pwm_period = dpx ? cmpa_reg : {period, 7'h00};
  wire [9:0] pwm_duty   = dpx ? {period, 7'h00} : cmpa_reg;
  // Period of zero means full range, so duty alone decides
  wire       pwm_active = (count_reg < pwm_duty) &&
                          ((pwm_period == 10'h000) || (count_reg < pwm_period));

  always @* begin
    out_next = out_reg;
    if (run_rise && (mode == `CTM_MODE_CMP)) begin
      out_next = init_lvl;
    end else if (mode == `CTM_MODE_CMP) begin
      if (a_match) begin
        case (io_fn)
          `CTM_IO_NONE:   out_next = out_reg;
          `CTM_IO_LOW:    out_next = 1'b0;
          `CTM_IO_HIGH:   out_next = 1'b1;
          `CTM_IO_TOGGLE: out_next = !out_reg;
          default:        out_next = out_reg;
        endcase
      end
    end else if (mode == `CTM_MODE_PWM) begin
      case (io_fn)
        `CTM_IO_NONE:   out_next = 1'b0;
        `CTM_IO_LOW:    out_next = 1'b1;
        `CTM_IO_HIGH:   out_next = pwm_active;
        `CTM_IO_TOGGLE: out_next = pwm_active;
        default:        out_next = 1'b0;
      endcase
    end
  end

  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  // timer mode frees the pin
  wire pin_used = run && ((mode == `CTM_MODE_CMP) || (mode == `CTM_MODE_PWM));
  wire pin_lvl  = out_next ^ pol;

  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      TIMER_OUTPUT_PIN_OE_OUT   <= 1'b0;
      TIMER_OUTPUT_PIN_B_OE_OUT <= 1'b0;
    end else begin
      TIMER_OUTPUT_PIN_OE_OUT   <= pin_used;
      TIMER_OUTPUT_PIN_B_OE_OUT <= pin_used;
    end
  end

  // Level launched with the internal state, no extra lag
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      TIMER_OUTPUT_PIN_OUT   <= 1'b0;
      TIMER_OUTPUT_PIN_B_OUT <= 1'b1;
    end else begin
      TIMER_OUTPUT_PIN_OUT   <= pin_lvl;
      TIMER_OUTPUT_PIN_B_OUT <= !pin_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ctrl0_reg <= `CTM_RST_CTRL0;
      ctrl1_reg <= `CTM_RST_CTRL1;
      cmpa_reg  <= `CTM_RST_CMPA;
    end else if (WR_EN_IN) begin
      if (hit(ADDR_IN, `CTM_ADDR_CTRL0)) begin
        ctrl0_reg <= WR_DATA_IN;
      end
      if (hit(ADDR_IN, `CTM_ADDR_CTRL1)) begin
        ctrl1_reg <= WR_DATA_IN;
      end
      if (hit(ADDR_IN, `CTM_ADDR_CMPA_HI)) begin
        cmpa_reg <= {WR_DATA_IN[1:0], hold_reg};
      end
    end
  end

  // ----------------------------------------------------------------
  // Holding buffer
  // ----------------------------------------------------------------
  // Shared by both pairs; interleaved access corrupts it
  // Strobes never overlap, so the order below is only a guard
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      hold_reg <= `CTM_RST_BYTE;
    end else if (WR_EN_IN && hit(ADDR_IN, `CTM_ADDR_CMPA_LO)) begin
      hold_reg <= WR_DATA_IN;
    end else if (RD_EN_IN && hit(ADDR_IN, `CTM_ADDR_CNT_HI)) begin
      hold_reg <= count_reg[7:0];
    end else if (RD_EN_IN && hit(ADDR_IN, `CTM_ADDR_CMPA_HI)) begin
      hold_reg <= cmpa_reg[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @* begin
    // Idle bus reads zero so a late sample sees nothing stale
    rd_next = 8'h00;
    if (RD_EN_IN) begin
      case (ADDR_IN)
        `CTM_ADDR_CTRL0:   rd_next = ctrl0_reg;
        `CTM_ADDR_CTRL1:   rd_next = ctrl1_reg;
        `CTM_ADDR_CNT_LO:  rd_next = hold_reg;
        `CTM_ADDR_CMPA_LO: rd_next = hold_reg;
        `CTM_ADDR_CNT_HI:  rd_next = {6'h00, count_reg[9:8]};
        `CTM_ADDR_CMPA_HI: rd_next = {6'h00, cmpa_reg[9:8]};
        default:           rd_next = 8'h00;
      endcase
    end
  end

  // counter pair has no write path
  always @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT <= 8'h00;
    end else begin
      RD_DATA_OUT <= rd_next;
    end
  end

endmodule

// *** shared/ctm_consts.vh ***
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define CTM_ADDR_CTRL0    3'h0
`define CTM_ADDR_CTRL1    3'h1
`define CTM_ADDR_CNT_LO   3'h2
`define CTM_ADDR_CNT_HI   3'h3
`define CTM_ADDR_CMPA_LO  3'h4
`define CTM_ADDR_CMPA_HI  3'h5

// ----------------------------------------------------------------
// First control register fields
// ----------------------------------------------------------------
`define CTM_C0_PAUSE      7
`define CTM_C0_CKSEL_HI   6
`define CTM_C0_CKSEL_LO   4
`define CTM_C0_RUN        3
`define CTM_C0_RP_HI      2
`define CTM_C0_RP_LO      0

// ----------------------------------------------------------------
// Second control register fields
// ----------------------------------------------------------------
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_IO_HI      5
`define CTM_C1_IO_LO      4
`define CTM_C1_INIT       3
`define CTM_C1_POL        2
`define CTM_C1_DPX        1
`define CTM_C1_CCLR       0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTM_RST_CTRL0     8'h00
`define CTM_RST_CTRL1     8'h00
`define CTM_RST_CNT       10'h000
`define CTM_RST_CMPA      10'h000
`define CTM_RST_BYTE      8'h00

// ----------------------------------------------------------------
// Clock select codes
// ----------------------------------------------------------------
`define CTM_CK_SYS_DIV4   3'h0
`define CTM_CK_SYS        3'h1
`define CTM_CK_HI_DIV16   3'h2
`define CTM_CK_HI_DIV64   3'h3
`define CTM_CK_TBC        3'h4
`define CTM_CK_NONE       3'h5
`define CTM_CK_EXT_RISE   3'h6
`define CTM_CK_EXT_FALL   3'h7

// ----------------------------------------------------------------
// Mode and output function codes
// ----------------------------------------------------------------
`define CTM_MODE_CMP      2'h0
`define CTM_MODE_RSVD     2'h1
`define CTM_MODE_PWM      2'h2
`define CTM_MODE_TIMER    2'h3
`define CTM_IO_NONE       2'h0
`define CTM_IO_LOW        2'h1
`define CTM_IO_HIGH       2'h2
`define CTM_IO_TOGGLE     2'h3

// ----------------------------------------------------------------
// Prescaler terminal counts
// ----------------------------------------------------------------
`define CTM_DIV4_MASK     6'h03
`define CTM_DIV16_MASK    6'h0f
`define CTM_DIV64_MASK    6'h3f

`endif

// *** verif/ctm_top_sva.sv ***
`timescale 1ns/1ps
module ctm_top_sva (
  // Clock, reset and register port
  input wire       CLOCK_IN,
  input wire       RST_N_IN,
  input wire [2:0] ADDR_IN,
  input wire [7:0] WR_DATA_IN,
  input wire       WR_EN_IN,
  input wire       RD_EN_IN,
  input wire [7:0] RD_DATA_OUT,
  // Pins and events
  input wire       TIMER_OUTPUT_PIN_OUT,
  input wire       TIMER_OUTPUT_PIN_OE_OUT,
  input wire       TIMER_OUTPUT_PIN_B_OUT,
  input wire       TIMER_OUTPUT_PIN_B_OE_OUT,
  input wire       PERIOD_MATCH_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  a_pin_b_inverse: assert property (
    TIMER_OUTPUT_PIN_B_OUT == !TIMER_OUTPUT_PIN_OUT)
    else $error("Second pin is not the inverse of the main pin");
  a_pin_b_enable: assert property (
    TIMER_OUTPUT_PIN_B_OE_OUT == TIMER_OUTPUT_PIN_OE_OUT)
    else $error("Second pin enable differs from main enable");
  a_hi_bits_zero: assert property (
    RD_EN_IN && (ADDR_IN == 3'h3 || ADDR_IN == 3'h5) |=> RD_DATA_OUT[7:2] == 6'h00)
    else $error("High byte read shows upper bits set");
  a_cmpa_pair_back: assert property (
    WR_EN_IN && ADDR_IN == 3'h5 ##2 RD_EN_IN && ADDR_IN == 3'h5
    |=> RD_DATA_OUT == {6'h00, $past(WR_DATA_IN[1:0], 3)})
    else $error("Compare high byte did not read back");
  a_ctrl_read_back: assert property (
    WR_EN_IN && ADDR_IN == 3'h0 ##2 RD_EN_IN && ADDR_IN == 3'h0
    |=> RD_DATA_OUT == $past(WR_DATA_IN, 3))
    else $error("Control register did not read back");
  a_rd_idle_zero: assert property (
    !RD_EN_IN |=> RD_DATA_OUT == 8'h00)
    else $error("Read data without a read strobe");
  a_period_spacing: assert property (
    $rose(PERIOD_MATCH_OUT) |=> !PERIOD_MATCH_OUT [*8])
    else $error("Period events closer than allowed");
  a_stop_releases: assert property (
    WR_EN_IN && ADDR_IN == 3'h0 && !WR_DATA_IN[3] |-> ##[1:3] !TIMER_OUTPUT_PIN_OE_OUT)
    else $error("Pin still owned after counter stop");
  a_timer_mode_pin: assert property (
    WR_EN_IN && ADDR_IN == 3'h1 && WR_DATA_IN[6] |-> ##[1:3] !TIMER_OUTPUT_PIN_OE_OUT)
    else $error("Pin owned in a mode without output");
endmodule

// *** verif/ctm_ext_pin_model.sv ***
`timescale 1ns/1ps
// Free running event source, phase unrelated to the system clock
module ctm_ext_pin_model #(
  parameter HALF_NS = 370
) (
  // Pin and edge tallies
  output reg     pin_out,
  output integer rises_out,
  output integer falls_out
);
  initial begin
    pin_out = 1'b0;
    rises_out = 0;
    falls_out = 0;
    forever begin
      #HALF_NS;
      pin_out = ~pin_out;
      if (pin_out) rises_out = rises_out + 1;
      else falls_out = falls_out + 1;
    end
  end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg  [2:0] addr = 3'h0;
  reg  [7:0] wdata = 8'h00;
  reg        wr_en = 1'b0;
  reg        rd_en = 1'b0;
  reg        tbc = 1'b0;
  reg  [2:0] tdiv = 3'h0;
  wire [7:0] rdata;
  wire       ext_pin, pin, pin_oe, pin_b, pin_b_oe, p_match, a_match;
  integer    ext_rises, ext_falls, bad_count = 0, checks = 0, cyc = 0, hi_cnt = 0;
  integer    p_last = 0, p_gap = 0, a_last = 0, a_gap = 0;
  // ------------------------------------------------------------
  // Design and partner
  // ------------------------------------------------------------
  ctm_top dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdata),
    .WR_EN_IN(wr_en), .RD_EN_IN(rd_en), .RD_DATA_OUT(rdata), .TBC_TICK_IN(tbc),
    .EXT_CLOCK_PIN_IN(ext_pin), .TIMER_OUTPUT_PIN_OUT(pin), .TIMER_OUTPUT_PIN_OE_OUT(pin_oe),
    .TIMER_OUTPUT_PIN_B_OUT(pin_b), .TIMER_OUTPUT_PIN_B_OE_OUT(pin_b_oe),
    .PERIOD_MATCH_OUT(p_match), .COMPARE_A_MATCH_OUT(a_match));
  ctm_ext_pin_model pin_u (.pin_out(ext_pin), .rises_out(ext_rises), .falls_out(ext_falls));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    tdiv <= tdiv + 3'h1;
    tbc <= (tdiv == 3'h7);
    cyc <= cyc + 1;
    if (pin === 1'b1) hi_cnt <= hi_cnt + 1;
    if (p_match === 1'b1) begin
      p_gap <= cyc - p_last;
      p_last <= cyc;
    end
    if (a_match === 1'b1) begin
      a_gap <= cyc - a_last;
      a_last <= cyc;
    end
  end
  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input [2:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input [2:0] a, output [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rdcnt(output [9:0] c);
    reg [7:0] h, l;
    rd(3'h3, h);
    rd(3'h2, l);
    c = {h[1:0], l};
  endtask
  task automatic settle(input integer n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic restart(input [7:0] c0);
    wr(3'h0, 8'h10);
    wr(3'h0, c0);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    integer a;
    reg [7:0] d;
    for (a = 0; a < 7; a = a + 1) begin
      rd(a[2:0], d);
      chk(d, 8'h00);
    end
    chk(pin_oe, 1'b0);
  endtask
  task automatic t_buffer;
    reg [7:0] d;
    reg [9:0] c;
    wr(3'h4, 8'h34);
    wr(3'h5, 8'hfd);
    rd(3'h5, d);
    chk(d, 8'h01);
    rd(3'h4, d);
    chk(d, 8'h34);
    wr(3'h4, 8'h56);
    rd(3'h5, d);
    rd(3'h4, d);
    chk(d, 8'h34);
    wr(3'h2, 8'haa);
    wr(3'h3, 8'h03);
    wr(3'h7, 8'hff);
    rd(3'h7, d);
    chk(d, 8'h00);
    rdcnt(c);
    chk(c, 10'h000);
  endtask
  task automatic t_clk_sel;
    integer s, r0, f0, e, t;
    reg [9:0] c, c2;
    for (s = 0; s < 8; s = s + 1) begin
      wr(3'h0, {1'b0, s[2:0], 4'h8});
      r0 = ext_rises;
      f0 = ext_falls;
      repeat (256) @(posedge clk);
      case (s)
        0: e = 64;
        1: e = 257;
        2: e = 16;
        3: e = 4;
        4: e = 32;
        5: e = 0;
        6: e = ext_rises - r0;
        default: e = ext_falls - f0;
      endcase
      t = (s == 5) ? 0 : 3;
      wr(3'h0, {1'b0, s[2:0], 4'h0});
      rdcnt(c);
      chk((c + t >= e) && (c <= e + t), 1'b1);
      repeat (20) @(posedge clk);
      rdcnt(c2);
      chk(c2, c);
    end
  endtask
  task automatic t_pause;
    reg [9:0] c1, c2, c3;
    restart(8'h18);
    repeat (50) @(posedge clk);
    wr(3'h0, 8'h98);
    rdcnt(c1);
    repeat (20) @(posedge clk);
    rdcnt(c2);
    chk(c2, c1);
    wr(3'h0, 8'h18);
    repeat (20) @(posedge clk);
    rdcnt(c3);
    chk(c3 > c2 && c3 < c2 + 40, 1'b1);
  endtask
  task automatic t_period;
    reg [7:0] d;
    restart(8'h19);
    rd(3'h0, d);
    chk(d, 8'h19);
    settle(300);
    chk(p_gap, 16'd128);
    restart(8'h18);
    settle(2100);
    chk(p_gap, 16'd1024);
  endtask
  task automatic t_compare;
    integer i, h;
    wr(3'h4, 8'h20);
    wr(3'h5, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      wr(3'h1, 8'h31 | (i << 3));
      restart(8'h18);
      settle(3);
      chk(pin, i[0]);
    end
    chk(pin_oe, 1'b1);
    settle(100);
    chk(a_gap, 16'd32);
    h = hi_cnt;
    settle(128);
    chk(hi_cnt - h, 16'd64);
    for (i = 0; i < 2; i = i + 1) begin
      wr(3'h1, i ? 8'h21 : 8'h19);
      restart(8'h18);
      settle(3);
      chk(pin, !i[0]);
      settle(40);
      chk(pin, i[0]);
    end
    wr(3'h0, 8'h10);
    settle(3);
    chk(pin_oe, 1'b0);
  endtask
  task automatic t_modes;
    integer m;
    for (m = 0; m < 4; m = m + 1) begin
      wr(3'h1, {m[1:0], 6'h20});
      restart(8'h18);
      settle(3);
      chk(pin_oe, m == 0 || m == 2);
    end
  endtask
  task automatic t_pwm;
    integer p, h;
    for (p = 0; p < 2; p = p + 1) begin
      wr(3'h1, 8'ha0 | (p << 2));
      restart(8'h19);
      settle(10);
      h = hi_cnt;
      settle(256);
      chk(hi_cnt - h, p ? 16'd192 : 16'd64);
    end
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h01);
    wr(3'h1, 8'ha3);
    restart(8'h19);
    settle(10);
    h = hi_cnt;
    settle(256);
    chk(hi_cnt - h, 16'd128);
    wr(3'h1, 8'h90);
    settle(3);
    chk(pin, 1'b1);
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_buffer;
    t_clk_sel;
    t_pause;
    t_period;
    t_compare;
    t_modes;
    t_pwm;
    print_verdict;
  end
  // Far beyond the planned run, so only a hang gets here
  initial begin
    repeat (30000) @(posedge clk);
    bad_count = bad_count + 1;
    print_verdict;
  end
endmodule

bind ctm_top ctm_top_sva sva_u (.CLOCK_IN, .RST_N_IN, .ADDR_IN, .WR_DATA_IN, .WR_EN_IN,
  .RD_EN_IN, .RD_DATA_OUT, .TIMER_OUTPUT_PIN_OUT, .TIMER_OUTPUT_PIN_OE_OUT,
  .TIMER_OUTPUT_PIN_B_OUT, .TIMER_OUTPUT_PIN_B_OE_OUT, .PERIOD_MATCH_OUT);
